//--- debug_mailbox_pkg.sv
// Constants for the processor to debugger word mailbox.
// Assumes a single 40 MHz system clock; scan strobes come from an external test port controller.
package debug_mailbox_pkg;
  localparam int WORD_W = 32;
  localparam int CHAIN_W = WORD_W + 2;
  localparam int CHAIN_NUM_W = 4;
  localparam int CTRL_RSVD_W = 26;
  localparam int SYNC_STAGES = 2;
  // Scan chain that reaches the mailbox
  localparam logic [CHAIN_NUM_W-1:0] MAILBOX_CHAIN = 4'h2;
  // Fixed version pattern in the top of the control word
  localparam logic [3:0] CTRL_VERSION = 4'h1;
  // Control word flag positions
  localparam int CTRL_W_BIT = 1;
  localparam int CTRL_R_BIT = 0;
  // Scan chain field positions: {write, address, data}
  localparam int CHAIN_WR_BIT = 33;
  localparam int CHAIN_ADDR_BIT = 32;
  localparam logic ADDR_CTRL = 1'b0;
  localparam logic ADDR_DATA = 1'b1;
  // Timing of the bench link clock and of the system clock
  localparam int TCK_PERIOD_NS = 200;
  localparam int CLK_PERIOD_NS = 25;
endpackage : debug_mailbox_pkg

//--- mailbox_sync.sv
// Plain two flip-flop synchroniser, any width.
// Assumes each bit is a level that changes slowly against clk_i.
`timescale 1ns/10ps
module mailbox_sync #(
  parameter int W = 1
) (
  input wire logic clk_i, // System clock
  input wire logic reset_i, // Async reset, active high
  input wire logic [W-1:0] d_i, // Asynchronous levels
  output logic [W-1:0] q_o // Synchronised levels
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_q <= '0;
      q_o <= '0;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule : mailbox_sync

//--- debug_mailbox.sv
// Word mailbox between a processor core and an external debugger.
// Assumes core transfer strobes are one-cycle pulses on clk_i and that the
// test port controller drives capture, shift, update and chain number from tck.
// Operation
// - A core write into the transmit data register sets the transmit-full flag.
// - The debugger sees both full flags only through a synchroniser.
// - A debugger read of the transmit data register clears transmit-full.
// - A debugger write into the receive data register sets receive-full.
// - A core read of the receive data register clears receive-full.
// - The receive-available output is high while an unread word is held.
// - The transmit-empty output is high while the transmit data register is free.
// - Both data registers are 32 bits wide.
// - The debugger reaches the mailbox through scan chain 2 only.
`timescale 1ns/10ps
module debug_mailbox (
  input wire logic clk_i, // System clock, 40 MHz
  input wire logic reset_i, // Async reset, active high
  input wire logic cp_wr_tx_i, // Core write pulse to transmit data
  input wire logic [31:0] cp_wdata_i, // Core write data
  input wire logic cp_rd_ctrl_i, // Core read pulse of control word
  input wire logic cp_rd_rx_i, // Core read pulse of receive data
  output logic [31:0] cp_rdata_o, // Core read data, valid cycle after pulse
  input wire logic tck_i, // Debugger test clock pin
  input wire logic tdi_i, // Debugger serial data in
  input wire logic capture_i, // Capture state of the test port
  input wire logic shift_i, // Shift state of the test port
  input wire logic update_i, // Update state of the test port
  input wire logic [3:0] chain_num_i, // Selected scan chain
  output logic tdo_o, // Serial data out
  output logic tx_empty_irq_o, // Transmit register free
  output logic rx_avail_irq_o // Receive word waiting
);
  logic [4:0] pins_s;
  logic [3:0] chain_s;
  logic tck_s, tdi_s, cap_s, sh_s, upd_s;
  logic tck_prev_q;
  logic w_q, w_d, r_q, r_d;
  logic [1:0] flags_dbg;
  logic [debug_mailbox_pkg::WORD_W-1:0] tx_q, rx_q;
  logic [debug_mailbox_pkg::CHAIN_W-1:0] chain_q, chain_d;
  logic addr_q;
  logic tck_rise, tck_fall, sel, do_cap, do_shift, do_upd, dbg_rd, dbg_wr;
  logic [31:0] ctrl_cpu, ctrl_dbg, cap_val;

  // Every debugger pin crosses two flip-flops before use
  mailbox_sync #(.W(5)) u_pin_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .d_i({tck_i, tdi_i, capture_i, shift_i, update_i}),
    .q_o(pins_s)
  );
  mailbox_sync #(.W(4)) u_chain_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .d_i(chain_num_i),
    .q_o(chain_s)
  );
  // The debugger view of the flags lags the core view by two cycles
  mailbox_sync #(.W(2)) u_flag_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .d_i({w_q, r_q}),
    .q_o(flags_dbg)
  );

  // Decode of the sampled test port
  assign {tck_s, tdi_s, cap_s, sh_s, upd_s} = pins_s;
  assign tck_rise = tck_s & ~tck_prev_q;
  assign tck_fall = ~tck_s & tck_prev_q;
  assign sel = (chain_s == debug_mailbox_pkg::MAILBOX_CHAIN);
  assign do_cap = tck_rise & sel & cap_s;
  assign do_shift = tck_rise & sel & sh_s;
  assign do_upd = tck_rise & sel & upd_s;
  assign dbg_rd = do_cap & (addr_q == debug_mailbox_pkg::ADDR_DATA);
  // A deposit while a word is still waiting is dropped, not overwritten
  assign dbg_wr = do_upd & chain_q[debug_mailbox_pkg::CHAIN_WR_BIT] & ~r_q
    & (chain_q[debug_mailbox_pkg::CHAIN_ADDR_BIT] == debug_mailbox_pkg::ADDR_DATA);

  // Control words; reserved bits read as zero
  assign ctrl_cpu = {debug_mailbox_pkg::CTRL_VERSION,
    {debug_mailbox_pkg::CTRL_RSVD_W{1'b0}}, w_q, r_q};
  assign ctrl_dbg = {debug_mailbox_pkg::CTRL_VERSION,
    {debug_mailbox_pkg::CTRL_RSVD_W{1'b0}}, flags_dbg};
  assign cap_val = (addr_q == debug_mailbox_pkg::ADDR_DATA) ? tx_q : ctrl_dbg;

  // Flag next state; a set in the same cycle as a clear wins
  assign w_d = cp_wr_tx_i | (w_q & ~dbg_rd);
  assign r_d = dbg_wr | (r_q & ~cp_rd_rx_i);

  // Scan register next state, shifting toward bit 0
  assign chain_d = do_cap ? {chain_q[debug_mailbox_pkg::CHAIN_W-1:debug_mailbox_pkg::WORD_W],
                             cap_val}
                 : do_shift ? {tdi_s, chain_q[debug_mailbox_pkg::CHAIN_W-1:1]}
                 : chain_q;

  // Handshake flags and their outputs
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      w_q <= 1'b0;
      r_q <= 1'b0;
      tx_empty_irq_o <= 1'b1;
      rx_avail_irq_o <= 1'b0;
    end else begin
      w_q <= w_d;
      r_q <= r_d;
      tx_empty_irq_o <= ~w_d;
      rx_avail_irq_o <= r_d;
    end
  end

  // Data registers; the core may overwrite transmit data, software must poll first
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_q <= '0;
      rx_q <= '0;
    end else begin
      if (cp_wr_tx_i) begin
        tx_q <= cp_wdata_i;
      end
      if (dbg_wr) begin
        rx_q <= chain_q[debug_mailbox_pkg::WORD_W-1:0];
      end
    end
  end

  // Core read port
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cp_rdata_o <= '0;
    end else if (cp_rd_ctrl_i) begin
      cp_rdata_o <= ctrl_cpu;
    end else if (cp_rd_rx_i) begin
      cp_rdata_o <= rx_q;
    end
  end

  // Scan side: address from an update steers the next capture
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tck_prev_q <= 1'b0;
      chain_q <= '0;
      addr_q <= debug_mailbox_pkg::ADDR_CTRL;
      tdo_o <= 1'b0;
    end else begin
      tck_prev_q <= tck_s;
      chain_q <= chain_d;
      if (do_upd) begin
        addr_q <= chain_q[debug_mailbox_pkg::CHAIN_ADDR_BIT];
      end
      if (tck_fall) begin
        tdo_o <= chain_q[0]; // Changes on the falling edge so the debugger samples it stable
      end
    end
  end

  // Checks
  chk_tx_set_full: assert property (@(posedge clk_i) disable iff (reset_i)
    cp_wr_tx_i |=> w_q && tx_q == $past(cp_wdata_i))
    else $error("transmit-full not set by core write");
  chk_flag_sync_lag: assert property (@(posedge clk_i) disable iff (reset_i)
    ##2 flags_dbg == $past({w_q, r_q}, 2))
    else $error("debugger flag view not two cycles behind");
  chk_tx_read_clear: assert property (@(posedge clk_i) disable iff (reset_i)
    dbg_rd && !cp_wr_tx_i |=> !w_q ##1 tx_empty_irq_o)
    else $error("debugger read did not free transmit");
  chk_rx_set_full: assert property (@(posedge clk_i) disable iff (reset_i)
    dbg_wr |=> r_q && rx_q == $past(chain_q[31:0]))
    else $error("debugger write did not fill receive");
  chk_rx_read_clear: assert property (@(posedge clk_i) disable iff (reset_i)
    cp_rd_rx_i && !dbg_wr |=> !r_q && cp_rdata_o == $past(rx_q))
    else $error("core read did not empty receive");
  chk_rx_avail_out: assert property (@(posedge clk_i) disable iff (reset_i)
    rx_avail_irq_o == r_q)
    else $error("receive-available not tracking flag");
  chk_tx_empty_out: assert property (@(posedge clk_i) disable iff (reset_i)
    tx_empty_irq_o == !w_q)
    else $error("transmit-empty not tracking flag");
  chk_chain_select: assert property (@(posedge clk_i) disable iff (reset_i)
    tck_rise && !sel |=> $stable(chain_q) && $stable(addr_q)
      && ($stable(r_q) || $past(cp_rd_rx_i)))
    else $error("mailbox touched by other chain");
  chk_reset_idle: assert property (@(posedge clk_i)
    reset_i |-> tx_empty_irq_o && !rx_avail_irq_o && !w_q && !r_q)
    else $error("reset state wrong");
endmodule : debug_mailbox

//--- debug_host_model.sv
// Debugger model: drives the test port pins of the mailbox scan chain.
// Assumes the mailbox samples every pin with its own clock; tck idles low between frames.
`timescale 1ns/10ps
module debug_host_model (
  output logic tck_o, // Test clock, low outside frames
  output logic tdi_o, // Serial data to the mailbox
  output logic capture_o, // Capture state
  output logic shift_o, // Shift state
  output logic update_o, // Update state
  output logic [3:0] chain_o, // Selected chain
  input wire logic tdo_i // Serial data from the mailbox
);
  // Idle pins at time zero
  initial begin
    {tck_o, tdi_o, capture_o, shift_o, update_o} = 5'h0;
    chain_o = 4'h0;
  end
  // One 200 ns period; tdo is taken late in the high phase since the mailbox lags a few clocks
  task automatic tick(output logic so);
    #100 tck_o = 1'b1;
    #99 so = tdo_i;
    #1 tck_o = 1'b0;
  endtask : tick
  // Optional capture, 34 shifts LSB first, then update
  task automatic frame(input logic [3:0] ch, input logic cap, input logic [33:0] din,
                       output logic [33:0] dout);
    logic s;
    chain_o = ch;
    capture_o = cap;
    if (cap) begin
      tick(s);
    end
    capture_o = 1'b0;
    shift_o = 1'b1;
    for (int i = 0; i < 34; i++) begin
      tdi_o = din[i];
      tick(dout[i]);
    end
    shift_o = 1'b0;
    tdi_o = ~din[33]; // Released line shows the inverse of its last bit
    update_o = 1'b1;
    tick(s);
    update_o = 1'b0;
    chain_o = 4'h0;
  endtask : frame
endmodule : debug_host_model

//--- tb_top.sv
// Self-checking bench for the debug word mailbox, with a debugger model on the scan pins.
// Assumes a 40 MHz clock; core strobes change on the falling clock edge.
`timescale 1ns/10ps
module tb_top;
  logic clk_i = 1'b0;
  logic reset_i = 1'b0;
  logic cp_wr_tx_i = 1'b0;
  logic [31:0] cp_wdata_i = 32'h0;
  logic cp_rd_ctrl_i = 1'b0;
  logic cp_rd_rx_i = 1'b0;
  logic [31:0] cp_rdata_o;
  logic tck, tdi, cap, sft, upd, tdo, tx_empty, rx_avail;
  logic [3:0] chain;
  int n_errors = 0;
  int total_checks = 0;
  always #12.5 clk_i = ~clk_i;
  debug_mailbox uut (.clk_i(clk_i), .reset_i(reset_i), .cp_wr_tx_i(cp_wr_tx_i),
    .cp_wdata_i(cp_wdata_i), .cp_rd_ctrl_i(cp_rd_ctrl_i), .cp_rd_rx_i(cp_rd_rx_i),
    .cp_rdata_o(cp_rdata_o), .tck_i(tck), .tdi_i(tdi), .capture_i(cap), .shift_i(sft),
    .update_i(upd), .chain_num_i(chain), .tdo_o(tdo), .tx_empty_irq_o(tx_empty),
    .rx_avail_irq_o(rx_avail));
  debug_host_model host (.tck_o(tck), .tdi_o(tdi), .capture_o(cap), .shift_o(sft),
    .update_o(upd), .chain_o(chain), .tdo_i(tdo));
  // Compare one value in hex
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test
  function automatic logic [31:0] ctl(input logic w, input logic r);
    return {debug_mailbox_pkg::CTRL_VERSION, 26'h0, w, r};
  endfunction : ctl
  // Core read strobe; data is taken half a cycle after the edge that takes it
  task automatic core_rd(input logic rx, output logic [31:0] v);
    @(negedge clk_i);
    cp_rd_ctrl_i = ~rx;
    cp_rd_rx_i = rx;
    @(negedge clk_i);
    {cp_rd_ctrl_i, cp_rd_rx_i} = 2'b00;
    v = cp_rdata_o;
  endtask : core_rd
  task automatic core_wr(input logic [31:0] d);
    @(negedge clk_i);
    cp_wr_tx_i = 1'b1;
    cp_wdata_i = d;
    @(negedge clk_i);
    cp_wr_tx_i = 1'b0;
  endtask : core_wr
  // Address frame first, so a capture never reads the transmit word by accident
  task automatic dbg_rd(input logic addr, output logic [31:0] v);
    logic [33:0] o;
    host.frame(4'h2, 1'b0, {1'b0, addr, 32'h0}, o);
    host.frame(4'h2, 1'b1, {1'b0, addr, 32'h0}, o);
    v = o[31:0];
  endtask : dbg_rd
  task automatic t_reset;
    logic [31:0] v;
    chk({31'h0, tx_empty}, 32'h1);
    chk({31'h0, rx_avail}, 32'h0);
    core_rd(1'b0, v);
    chk(v, ctl(1'b0, 1'b0));
  endtask : t_reset
  task automatic t_send(input logic [31:0] d);
    logic [31:0] v;
    core_rd(1'b0, v);
    chk(v, ctl(1'b0, 1'b0));
    core_wr(d);
    chk({31'h0, tx_empty}, 32'h0);
    core_rd(1'b0, v);
    chk(v, ctl(1'b1, 1'b0));
    dbg_rd(1'b0, v);
    chk(v, ctl(1'b1, 1'b0));
    core_rd(1'b0, v);
    chk(v, ctl(1'b1, 1'b0));
    dbg_rd(1'b1, v);
    chk(v, d);
    chk({31'h0, tx_empty}, 32'h1);
    core_rd(1'b0, v);
    chk(v, ctl(1'b0, 1'b0));
  endtask : t_send
  task automatic t_recv(input logic [31:0] d);
    logic [31:0] v;
    logic [33:0] o;
    dbg_rd(1'b0, v);
    chk(v, ctl(1'b0, 1'b0));
    host.frame(4'h2, 1'b0, {2'b11, d}, o);
    repeat (8) @(negedge clk_i);
    chk({31'h0, rx_avail}, 32'h1);
    host.frame(4'h2, 1'b0, {2'b11, ~d}, o); // Refused while the word is unread
    core_rd(1'b0, v);
    chk(v, ctl(1'b0, 1'b1));
    core_rd(1'b1, v);
    chk(v, d);
    chk({31'h0, rx_avail}, 32'h0);
    dbg_rd(1'b0, v);
    chk(v, ctl(1'b0, 1'b0));
  endtask : t_recv
  task automatic t_chain;
    logic [33:0] o;
    host.frame(4'h3, 1'b0, {2'b11, 32'h5A5A_0F0F}, o);
    repeat (8) @(negedge clk_i);
    chk({31'h0, rx_avail}, 32'h0);
  endtask : t_chain
  // Main sequence
  initial begin
    #1 reset_i = 1'b1; // A real rising edge, so the async reset acts before the first clock
    repeat (10) @(negedge clk_i);
    reset_i = 1'b0;
    t_reset();
    t_send(32'hA5C3_0F81);
    t_send(32'h0000_0001);
    t_recv(32'h1234_5678);
    t_chain();
    t_recv(32'hFFFF_FFFE);
    stop_test();
  end
  // Watchdog, far beyond the roughly 150 us the tests need
  initial begin
    #2_000_000;
    n_errors++;
    stop_test();
  end
endmodule : tb_top
